// ==== rtl/mcb_regbank.sv ====
// core register bank: timer, program counter with stack, status, ports, interrupt flags
// assumes the core presents one instruction per accepted instruction cycle
// Function
// - address zero reaches the register named by the RAM select pointer
// - timer counts instruction cycles, or chosen edge of the timer pin
// - prescaler serves the timer when assign bit clear, watchdog when set
// - prescaler cleared on software write of timer, and by watchdog clear or sleep while assigned to the watchdog
// - ratio code gives timer 2^(code+1), watchdog 2^code division
// - program counter and stack entries are ten bits wide
// - reset clears the program counter
// - jump loads target; call pushes next address then loads target
// - return variants load program counter from stack top
// - writing program counter register clears its two upper bits
// - program counter changing instructions take one extra cycle
// - pointer bits 5..0 select registers; bits 7,6 read one
// - reset type bit one on pin change wake, zero otherwise
// - time-out bit set by sleep, watchdog clear, power up; cleared on time-out
// - power-down bit set at power on or watchdog clear; cleared by sleep
// - port A has four bits, upper read zero; port B pin three input only
// - flags set on interrupt pin fall, port B change, timer overflow
// - software only clears flags; read returns flags AND mask
// - global enable cleared by disable or entry, set by enable or return from interrupt
// - control register reached only by control read and write instructions
// - direction bit zero drives the pin, one floats it
// - pull-down bits active low; bits 7 and 3 read one
// - mask bits enable external, port change and timer interrupts
module mcb_regbank (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_div4_sel,
  // instruction cycle
  output logic inst_cycle,
  output logic inst_take,
  // register access
  input wire logic [5:0] reg_addr,
  input wire logic reg_ioc,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // alu flags
  input wire logic alu_flags_we,
  input wire logic [2:0] alu_flags,
  // flow instructions
  input wire logic jump_instr,
  input wire logic call_instr,
  input wire logic [9:0] jump_target,
  input wire logic return_instr,
  input wire logic return_literal_instr,
  input wire logic return_from_irq_instr,
  output logic [9:0] program_counter,
  // control instructions
  input wire logic control_write_instr,
  input wire logic control_read_instr,
  input wire logic irq_enable_instr,
  input wire logic irq_disable_instr,
  input wire logic irq_entry,
  input wire logic sleep_instr,
  input wire logic watchdog_clear_instr,
  // watchdog and reset causes
  input wire logic wdt_tick,
  input wire logic wdt_timeout,
  output logic wdt_prescaled,
  input wire logic wake_on_pin_change,
  input wire logic other_reset_cause,
  // pins
  input wire logic timer_pin,
  input wire logic ext_irq_pin_n,
  input wire logic [3:0] port_a_in,
  output logic [3:0] port_a_out,
  output logic [3:0] port_a_oe,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe,
  output logic [7:0] pulldown_enable_n,
  // interrupt request to core
  output logic irq_request
);

  typedef struct packed {
    logic [1:0] div;
    logic cyc;
    logic wait_cyc;
    logic [9:0] pc;
    logic [mcb_pkg::STACK_DEPTH-1:0][9:0] stk;
    logic [7:0] timer;
    logic [7:0] pre;
    logic wdt_out;
    logic [7:0] status;
    logic [5:0] ram_sel;
    logic [3:0] pa_dat;
    logic [3:0] pa_dir;
    logic [7:0] pb_dat;
    logic [7:0] pb_dir;
    logic [7:0] pulldn;
    logic [2:0] flags;
    logic [2:0] mask;
    logic [7:0] ctrl;
    logic [mcb_pkg::GPR_WORDS-1:0][7:0] gpr;
    logic [mcb_pkg::SY_W-1:0] sy1;
    logic [mcb_pkg::SY_W-1:0] sy2;
    logic [mcb_pkg::SY_W-1:0] sy3;
    logic [mcb_pkg::SY_W-1:0] stable;
    logic [1:0] warm;
    logic [7:0] rdata;
  } mcb_state_t;

  mcb_state_t st;
  mcb_state_t next_st;

  logic take;
  logic [5:0] eff;
  logic eff_ok;
  logic wr_r;
  logic pc_chg;
  logic [mcb_pkg::SY_W-1:0] chg;
  logic [mcb_pkg::SY_W-1:0] pins;
  logic [7:0] rd_val;
  logic [7:0] lowmask_t;
  logic [7:0] lowmask_w;
  logic tmr_evt;
  logic tmr_inc;
  logic tmr_write;
  logic [4:0] gidx;

  assign take = st.cyc & ~st.wait_cyc;
  assign pins = {~ext_irq_pin_n, timer_pin, port_a_in, port_b_in};
  // indirect access resolves through the pointer; a pointer of zero reaches nothing
  assign eff = (reg_addr == mcb_pkg::ADDR_INDIRECT) ? st.ram_sel : reg_addr;
  assign eff_ok = eff != mcb_pkg::ADDR_INDIRECT;
  assign wr_r = take & reg_wr & ~reg_ioc & eff_ok;
  assign gidx = 5'(eff - mcb_pkg::ADDR_GPR_FIRST);
  assign pc_chg = jump_instr | call_instr | return_instr | return_literal_instr | return_from_irq_instr |
                  (wr_r & (eff == mcb_pkg::ADDR_PC_LOW));
  // a change counts once the second and third stages agree
  assign chg = {mcb_pkg::SY_W{&st.warm}} & ~(st.sy2 ^ st.sy3) & (st.sy3 ^ st.stable);
  assign tmr_write = wr_r & (eff == mcb_pkg::ADDR_TIMER);
  assign lowmask_t = 8'((9'h002 << st.ctrl[2:0]) - 9'h001);
  assign lowmask_w = 8'((9'h001 << st.ctrl[2:0]) - 9'h001);
  // internal cycle clock or selected pin edge
  assign tmr_evt = st.ctrl[mcb_pkg::CTL_SRC] ?
                   (chg[mcb_pkg::SY_TMR] & (st.sy3[mcb_pkg::SY_TMR] == ~st.ctrl[mcb_pkg::CTL_EDGE])) :
                   st.cyc;
  // prescaler divides timer events only while assigned to the timer
  assign tmr_inc = tmr_evt & (st.ctrl[mcb_pkg::CTL_PAB] | (&(st.pre | ~lowmask_t)));

  // register read mux
  always_comb begin
    rd_val = 8'h00;
    if (reg_ioc) begin
      case (eff)
        mcb_pkg::ADDR_PORT_A: rd_val = {4'h0, st.pa_dir};
        mcb_pkg::ADDR_PORT_B: rd_val = st.pb_dir;
        mcb_pkg::ADDR_PULLDOWN: rd_val = st.pulldn | mcb_pkg::PULLDOWN_FIXED;
        mcb_pkg::ADDR_IRQ: rd_val = {5'h00, st.mask} | mcb_pkg::MASK_FIXED;
        default: rd_val = 8'h00;
      endcase
    end else begin
      case (eff)
        mcb_pkg::ADDR_TIMER: rd_val = st.timer;
        mcb_pkg::ADDR_PC_LOW: rd_val = st.pc[7:0];
        mcb_pkg::ADDR_STATUS: rd_val = st.status;
        mcb_pkg::ADDR_RAM_SEL: rd_val = {2'h0, st.ram_sel} | mcb_pkg::RAM_SEL_FIXED;
        mcb_pkg::ADDR_PORT_A: rd_val = {4'h0, (st.pa_dat & ~st.pa_dir) |
                                        (st.stable[mcb_pkg::SY_PA +: 4] & st.pa_dir)};
        mcb_pkg::ADDR_PORT_B: rd_val = (st.pb_dat & ~st.pb_dir) | (st.stable[mcb_pkg::SY_PB +: 8] & st.pb_dir);
        mcb_pkg::ADDR_IRQ: rd_val = {5'h00, st.flags & st.mask};
        default: begin
          if (eff >= mcb_pkg::ADDR_GPR_FIRST && eff <= mcb_pkg::ADDR_GPR_LAST) begin
            rd_val = st.gpr[gidx];
          end
        end
      endcase
    end
  end

  always_comb begin
    next_st = st;
    // instruction cycle divider
    next_st.cyc = 1'b0;
    if (st.div == (clk_div4_sel ? mcb_pkg::DIV4_END : mcb_pkg::DIV2_END)) begin
      next_st.div = 2'h0;
      next_st.cyc = 1'b1;
    end else begin
      next_st.div = 2'(st.div + 2'h1);
    end
    // extra cycle after a program counter change
    if (take & pc_chg) begin
      next_st.wait_cyc = 1'b1;
    end else if (st.cyc) begin
      next_st.wait_cyc = 1'b0;
    end
    // input synchronisers
    next_st.sy1 = pins;
    next_st.sy2 = st.sy1;
    next_st.sy3 = st.sy2;
    next_st.stable = st.stable ^ chg;
    if (!(&st.warm)) begin
      next_st.warm = 2'(st.warm + 2'h1);
      next_st.stable = st.sy2;
    end
    // program counter and stack
    if (take) begin
      if (jump_instr) begin
        next_st.pc = jump_target;
      end else if (call_instr) begin
        next_st.stk = {st.stk[mcb_pkg::STACK_DEPTH-2:0], 10'(st.pc + 10'h001)};
        next_st.pc = jump_target;
      end else if (return_instr | return_literal_instr | return_from_irq_instr) begin
        next_st.pc = st.stk[0];
        next_st.stk = {st.stk[mcb_pkg::STACK_DEPTH-1], st.stk[mcb_pkg::STACK_DEPTH-1:1]};
      end else if (wr_r & (eff == mcb_pkg::ADDR_PC_LOW)) begin
        next_st.pc = {2'h0, reg_wdata};
      end else begin
        next_st.pc = 10'(st.pc + 10'h001);
      end
    end
    // timer and prescaler
    if (tmr_write) begin
      next_st.timer = reg_wdata;
      next_st.pre = 8'h00;
    end else begin
      if (tmr_inc) begin
        next_st.timer = 8'(st.timer + 8'h01);
      end
      if (st.ctrl[mcb_pkg::CTL_PAB]) begin
        if (take & (watchdog_clear_instr | sleep_instr)) begin
          next_st.pre = 8'h00;
        end else if (wdt_tick) begin
          next_st.pre = 8'(st.pre + 8'h01);
        end
      end else if (tmr_evt) begin
        next_st.pre = 8'(st.pre + 8'h01);
      end
    end
    next_st.wdt_out = st.ctrl[mcb_pkg::CTL_PAB] & wdt_tick & (&(st.pre | ~lowmask_w));
    // plain register writes
    if (wr_r) begin
      case (eff)
        mcb_pkg::ADDR_STATUS: next_st.status = (st.status & ~mcb_pkg::ST_SW_MASK) |
                                               (reg_wdata & mcb_pkg::ST_SW_MASK);
        mcb_pkg::ADDR_RAM_SEL: next_st.ram_sel = reg_wdata[5:0];
        mcb_pkg::ADDR_PORT_A: next_st.pa_dat = reg_wdata[3:0];
        mcb_pkg::ADDR_PORT_B: next_st.pb_dat = reg_wdata;
        mcb_pkg::ADDR_IRQ: next_st.flags = st.flags & reg_wdata[2:0];
        default: begin
          if (eff >= mcb_pkg::ADDR_GPR_FIRST && eff <= mcb_pkg::ADDR_GPR_LAST) begin
            next_st.gpr[gidx] = reg_wdata;
          end
        end
      endcase
    end
    if (take & reg_wr & reg_ioc) begin
      case (eff)
        mcb_pkg::ADDR_PORT_A: next_st.pa_dir = reg_wdata[3:0];
        mcb_pkg::ADDR_PORT_B: next_st.pb_dir = reg_wdata;
        mcb_pkg::ADDR_PULLDOWN: next_st.pulldn = reg_wdata;
        mcb_pkg::ADDR_IRQ: next_st.mask = reg_wdata[2:0];
        default: next_st.mask = next_st.mask;
      endcase
    end
    // hardware flag sets win over a clearing write
    if (chg[mcb_pkg::SY_INT] & st.sy3[mcb_pkg::SY_INT]) begin
      next_st.flags[2] = 1'b1;
    end
    if (|chg[mcb_pkg::SY_PB +: 8]) begin
      next_st.flags[1] = 1'b1;
    end
    if (tmr_inc & (st.timer == 8'hFF) & ~tmr_write) begin
      next_st.flags[0] = 1'b1;
    end
    // status flags from core and events
    if (take & alu_flags_we) begin
      next_st.status[2:0] = alu_flags;
    end
    if (take & sleep_instr) begin
      next_st.status[mcb_pkg::ST_TO] = 1'b1;
      next_st.status[mcb_pkg::ST_PD] = 1'b0;
    end
    if (take & watchdog_clear_instr) begin
      next_st.status[mcb_pkg::ST_TO] = 1'b1;
      next_st.status[mcb_pkg::ST_PD] = 1'b1;
    end
    if (wdt_timeout) begin
      next_st.status[mcb_pkg::ST_TO] = 1'b0;
    end
    if (wake_on_pin_change) begin
      next_st.status[mcb_pkg::ST_RST] = 1'b1;
    end else if (other_reset_cause | wdt_timeout) begin
      next_st.status[mcb_pkg::ST_RST] = 1'b0;
    end
    // control register only through its own instructions
    if (take & control_write_instr) begin
      next_st.ctrl = reg_wdata;
    end
    if ((take & irq_disable_instr) | irq_entry) begin
      next_st.ctrl[mcb_pkg::CTL_GIE] = 1'b0;
    end else if (take & (irq_enable_instr | return_from_irq_instr)) begin
      next_st.ctrl[mcb_pkg::CTL_GIE] = 1'b1;
    end
    // read data captured on the accepted cycle
    if (take) begin
      next_st.rdata = control_read_instr ? st.ctrl : rd_val;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
      st.pc <= mcb_pkg::PC_RESET;
      st.status <= mcb_pkg::STATUS_RESET;
      st.ctrl <= mcb_pkg::CTRL_RESET;
      st.pa_dir <= mcb_pkg::DIR_RESET[3:0];
      st.pb_dir <= mcb_pkg::DIR_RESET;
      st.pulldn <= mcb_pkg::PULLDOWN_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign inst_cycle = st.cyc;
  assign inst_take = take;
  assign reg_rdata = st.rdata;
  assign program_counter = st.pc;
  assign wdt_prescaled = st.wdt_out;
  assign port_a_out = st.pa_dat;
  assign port_a_oe = ~st.pa_dir;
  assign port_b_out = st.pb_dat;
  assign port_b_oe = ~st.pb_dir & 8'hF7;
  assign pulldown_enable_n = st.pulldn | mcb_pkg::PULLDOWN_FIXED;
  assign irq_request = st.ctrl[mcb_pkg::CTL_GIE] & (|(st.flags & st.mask));

  sequence s_wait_next;
    ##[1:4] st.cyc;
  endsequence

  AST_JUMP: assert property (@(posedge clk) disable iff (!rst_b)
    take && jump_instr |=> st.pc == $past(jump_target)) else $error("jump target not loaded");
  AST_CALL: assert property (@(posedge clk) disable iff (!rst_b)
    take && call_instr && !jump_instr |=> st.stk[0] == 10'($past(st.pc) + 10'h001) && st.pc == $past(jump_target))
    else $error("call push wrong");
  AST_RET: assert property (@(posedge clk) disable iff (!rst_b)
    take && return_instr && !jump_instr && !call_instr |=> st.pc == $past(st.stk[0]))
    else $error("return did not pop stack");
  AST_PC_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
    wr_r && eff == mcb_pkg::ADDR_PC_LOW && !jump_instr && !call_instr && !return_instr &&
    !return_literal_instr && !return_from_irq_instr |=> st.pc == {2'h0, $past(reg_wdata)})
    else $error("pc upper bits not cleared");
  AST_EXTRA_CYCLE: assert property (@(posedge clk) disable iff (!rst_b)
    take && pc_chg |=> (!take) throughout s_wait_next) else $error("no extra cycle");
  AST_PRESCALE_CLR: assert property (@(posedge clk) disable iff (!rst_b)
    tmr_write |=> st.pre == 8'h00 && st.timer == $past(reg_wdata)) else $error("prescaler not cleared");
  AST_WRAP: assert property (@(posedge clk) disable iff (!rst_b)
    tmr_inc && st.timer == 8'hFF && !tmr_write |=> st.timer == 8'h00 && st.flags[0])
    else $error("timer wrap without flag");
  AST_FLAG_READ: assert property (@(posedge clk) disable iff (!rst_b)
    take && !control_read_instr && !reg_ioc && eff == mcb_pkg::ADDR_IRQ |=>
    reg_rdata == {5'h00, $past(st.flags) & $past(st.mask)}) else $error("flag read not masked");
  AST_GIE_OFF: assert property (@(posedge clk) disable iff (!rst_b)
    irq_entry |=> !st.ctrl[mcb_pkg::CTL_GIE] && !irq_request) else $error("global enable not cleared");
  AST_RAM_SEL_TOP: assert property (@(posedge clk) disable iff (!rst_b)
    take && !control_read_instr && !reg_ioc && reg_addr == mcb_pkg::ADDR_RAM_SEL |=> reg_rdata[7:6] == 2'h3)
    else $error("pointer top bits not one");

endmodule

// ==== rtl/mcb_pkg.sv ====
// constants for the core register bank: addresses, field positions, reset values
// assumes a single 100 MHz clock and an active low asynchronous reset
package mcb_pkg;
  // data space addresses
  localparam logic [5:0] ADDR_INDIRECT = 6'h00;
  localparam logic [5:0] ADDR_TIMER = 6'h01;
  localparam logic [5:0] ADDR_PC_LOW = 6'h02;
  localparam logic [5:0] ADDR_STATUS = 6'h03;
  localparam logic [5:0] ADDR_RAM_SEL = 6'h04;
  localparam logic [5:0] ADDR_PORT_A = 6'h05;
  localparam logic [5:0] ADDR_PORT_B = 6'h06;
  localparam logic [5:0] ADDR_PULLDOWN = 6'h0B;
  localparam logic [5:0] ADDR_IRQ = 6'h0F;
  localparam logic [5:0] ADDR_GPR_FIRST = 6'h10;
  localparam logic [5:0] ADDR_GPR_LAST = 6'h2F;
  // control register fields
  localparam int CTL_GIE = 6;
  localparam int CTL_SRC = 5;
  localparam int CTL_EDGE = 4;
  localparam int CTL_PAB = 3;
  // status register fields
  localparam int ST_RST = 7;
  localparam int ST_TO = 4;
  localparam int ST_PD = 3;
  localparam logic [7:0] ST_SW_MASK = 8'h67;
  // synchronised input vector layout
  localparam int SY_PB = 0;
  localparam int SY_PA = 8;
  localparam int SY_TMR = 12;
  localparam int SY_INT = 13;
  localparam int SY_W = 14;
  // fixed read bits
  localparam logic [7:0] RAM_SEL_FIXED = 8'hC0;
  localparam logic [7:0] PULLDOWN_FIXED = 8'h88;
  localparam logic [7:0] MASK_FIXED = 8'hF8;
  // reset values
  localparam logic [9:0] PC_RESET = 10'h000;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [7:0] CTRL_RESET = 8'h3F;
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [7:0] PULLDOWN_RESET = 8'hFF;
  // sizes and divider ends
  localparam int STACK_DEPTH = 5;
  localparam int GPR_WORDS = 32;
  localparam logic [1:0] DIV2_END = 2'h1;
  localparam logic [1:0] DIV4_END = 2'h3;
endpackage

// ==== sim/mcb_core_model.sv ====
// core side model: holds one instruction until the bank takes it
// assumes the bench pulses go with a command; kind 0 is a plain access
module mcb_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bench side
  input wire logic go,
  input wire logic [3:0] kind,
  input wire logic [25:0] fields,
  output logic busy,
  // bank side
  input wire logic inst_take,
  output logic [5:0] reg_addr,
  output logic reg_ioc,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic [9:0] jump_target,
  output logic [11:1] op
);
  logic [25:0] f;
  logic [3:0] k;
  logic unused_wr;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      f <= 26'h0;
      k <= 4'h0;
    end else if (go) begin
      busy <= 1'b1;
      f <= fields;
      k <= kind;
    end else if (inst_take) begin
      busy <= 1'b0;
    end
  end
  // idle: strobes low, data lines show the inverse of the last value
  assign {unused_wr, reg_ioc, reg_addr, reg_wdata, jump_target} = busy ? f : ~f;
  assign reg_wr = busy & f[25];
  always_comb begin
    op = 11'h0;
    if (busy && k != 4'h0) begin
      op[k] = 1'b1;
    end
  end
endmodule

// ==== sim/mcb_core_register_bank_bench.sv ====
// bench for the core register bank: instruction sequences with expected values
// assumes the core model in front of the bank and a 100 MHz clock
module mcb_core_register_bank_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic go = 1'b0;
  logic [3:0] kind = 4'h0;
  logic [25:0] fields = 26'h0;
  logic timer_pin = 1'b0, ext_irq_pin_n = 1'b1, irq_entry = 1'b0, wdt_tick = 1'b0;
  logic wdt_timeout = 1'b0, wake = 1'b0, other = 1'b0;
  logic [7:0] port_b_in = 8'h00;
  logic div4 = 1'b0;
  logic inst_cycle;
  logic [7:0] port_b_out;
  int cyc_n = 0;
  logic busy, inst_take, reg_ioc, reg_wr, wdt_prescaled, irq_request;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, port_b_oe, pulldown_enable_n;
  logic [9:0] jump_target, program_counter, pc_at, saved;
  logic [11:1] op;
  logic [3:0] port_a_out, port_a_oe;
  int failures = 0;
  int tests_run = 0;
  int n = 0;
  int n0;
  always #5 clk = ~clk;
  always @(posedge clk) if (wdt_prescaled === 1'b1) n <= n + 1;
  always @(posedge clk) if (inst_cycle === 1'b1) cyc_n <= cyc_n + 1;
  mcb_core_model core (
    .clk(clk), .rst_b(rst_b), .go(go), .kind(kind), .fields(fields), .busy(busy), .inst_take(inst_take),
    .reg_addr(reg_addr), .reg_ioc(reg_ioc), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .jump_target(jump_target), .op(op)
  );
  mcb_regbank DUT (
    .clk(clk), .rst_b(rst_b), .clk_div4_sel(div4), .inst_cycle(inst_cycle), .inst_take(inst_take),
    .reg_addr(reg_addr), .reg_ioc(reg_ioc), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .alu_flags_we(1'b0), .alu_flags(3'h0), .jump_instr(op[1]), .call_instr(op[2]), .jump_target(jump_target),
    .return_instr(op[3]), .return_literal_instr(op[4]), .return_from_irq_instr(op[5]),
    .program_counter(program_counter), .control_write_instr(op[6]), .control_read_instr(op[7]),
    .irq_enable_instr(op[8]), .irq_disable_instr(op[9]), .irq_entry(irq_entry), .sleep_instr(op[10]),
    .watchdog_clear_instr(op[11]), .wdt_tick(wdt_tick), .wdt_timeout(wdt_timeout),
    .wdt_prescaled(wdt_prescaled), .wake_on_pin_change(wake), .other_reset_cause(other),
    .timer_pin(timer_pin), .ext_irq_pin_n(ext_irq_pin_n), .port_a_in(4'h0), .port_a_out(port_a_out),
    .port_a_oe(port_a_oe), .port_b_in(port_b_in), .port_b_out(port_b_out), .port_b_oe(port_b_oe),
    .pulldown_enable_n(pulldown_enable_n), .irq_request(irq_request)
  );
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hand one instruction to the model, wait for the take edge
  task automatic op_do(input logic [3:0] k, input logic [25:0] f);
    int i;
    @(posedge clk);
    go <= 1'b1;
    kind <= k;
    fields <= f;
    @(posedge clk);
    go <= 1'b0;
    #1;
    for (i = 0; i < 40 && busy; i++) begin
      pc_at = program_counter;
      @(posedge clk);
      #1;
    end
    if (busy) begin
      failures++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic io, input logic [7:0] d);
    op_do(4'h0, {1'b1, io, a, d, 10'h000});
  endtask
  task automatic rd(input logic [5:0] a, input logic io, input logic [7:0] e);
    op_do(4'h0, {1'b0, io, a, 8'h00, 10'h000});
    chk(reg_rdata, e);
  endtask
  task automatic fl(input logic [3:0] k, input logic [7:0] d, input logic [9:0] t);
    op_do(k, {2'b00, 6'h00, d, t});
  endtask
  task automatic tpin(input int cnt);
    repeat (cnt) begin
      @(posedge clk) timer_pin <= 1'b1;
      repeat (8) @(posedge clk);
      timer_pin <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1;
    chk(program_counter, 10'h000);
    chk(port_b_oe, 8'h00);
    @(posedge clk) rst_b <= 1'b1;
    rd(6'h04, 1'b0, 8'hC0);
    rd(6'h0B, 1'b1, 8'hFF);
    wr(6'h0B, 1'b1, 8'h00);
    rd(6'h0B, 1'b1, 8'h88);
    chk(pulldown_enable_n, 8'h88);
    wr(6'h05, 1'b1, 8'h00);
    chk(port_a_oe, 4'hF);
    wr(6'h05, 1'b0, 8'hFF);
    rd(6'h05, 1'b0, 8'h0F);
    chk(port_a_out, 4'hF);
    wr(6'h06, 1'b1, 8'h00);
    chk(port_b_oe, 8'hF7);
    wr(6'h06, 1'b0, 8'hA5);
    rd(6'h06, 1'b0, 8'hA5);
    chk(port_b_out, 8'hA5);
    wr(6'h04, 1'b0, 8'h10);
    wr(6'h00, 1'b0, 8'h5A);
    rd(6'h10, 1'b0, 8'h5A);
    rd(6'h04, 1'b0, 8'hD0);
    // external timer edges, rising then falling
    fl(4'h6, 8'h28, 10'h000);
    op_do(4'h7, 26'h0);
    chk(reg_rdata, 8'h28);
    wr(6'h01, 1'b0, 8'hFE);
    tpin(3);
    rd(6'h01, 1'b0, 8'h01);
    wr(6'h0F, 1'b1, 8'h01);
    rd(6'h0F, 1'b0, 8'h01);
    wr(6'h0F, 1'b0, 8'h00);
    rd(6'h0F, 1'b0, 8'h00);
    fl(4'h6, 8'h38, 10'h000);
    wr(6'h01, 1'b0, 8'h10);
    tpin(2);
    rd(6'h01, 1'b0, 8'h12);
    // every ratio code: 2^(code+1) edges give one count
    for (int c = 0; c < 8; c++) begin
      fl(4'h6, 8'h20 | 8'(c), 10'h000);
      wr(6'h01, 1'b0, 8'h00);
      tpin(2 << c);
      rd(6'h01, 1'b0, 8'h01);
    end
    fl(4'h6, 8'h20, 10'h000);
    wr(6'h01, 1'b0, 8'h00);
    tpin(1);
    wr(6'h01, 1'b0, 8'h00);
    tpin(1);
    rd(6'h01, 1'b0, 8'h00);
    tpin(1);
    rd(6'h01, 1'b0, 8'h01);
    // internal source, no prescaler: one count per instruction cycle of two clocks
    fl(4'h6, 8'h08, 10'h000);
    wr(6'h01, 1'b0, 8'h00);
    repeat (20) @(posedge clk);
    rd(6'h01, 1'b0, 8'h0B);
    // slow cycle rate: one instruction cycle per four clocks
    @(posedge clk) div4 <= 1'b1;
    repeat (4) @(posedge clk);
    n0 = cyc_n;
    repeat (20) @(posedge clk);
    chk(10'(cyc_n - n0), 10'h005);
    div4 <= 1'b0;
    repeat (4) @(posedge clk);
    // prescaler on the watchdog side, ratio 1:2
    fl(4'h6, 8'h29, 10'h000);
    fl(4'hB, 8'h00, 10'h000);
    n0 = n;
    repeat (4) begin
      @(posedge clk) wdt_tick <= 1'b1;
      @(posedge clk) wdt_tick <= 1'b0;
      repeat (3) @(posedge clk);
    end
    chk(10'(n - n0), 10'h002);
    fl(4'hA, 8'h00, 10'h000);
    rd(6'h03, 1'b0, 8'h10);
    @(posedge clk) wdt_timeout <= 1'b1;
    @(posedge clk) wdt_timeout <= 1'b0;
    rd(6'h03, 1'b0, 8'h00);
    fl(4'hB, 8'h00, 10'h000);
    rd(6'h03, 1'b0, 8'h18);
    @(posedge clk) wake <= 1'b1;
    @(posedge clk) wake <= 1'b0;
    rd(6'h03, 1'b0, 8'h98);
    @(posedge clk) other <= 1'b1;
    @(posedge clk) other <= 1'b0;
    rd(6'h03, 1'b0, 8'h18);
    // interrupt pin fall and input-only pin change
    @(posedge clk) ext_irq_pin_n <= 1'b0;
    port_b_in <= 8'h08;
    repeat (8) @(posedge clk);
    wr(6'h0F, 1'b1, 8'h07);
    rd(6'h0F, 1'b0, 8'h06);
    wr(6'h0F, 1'b1, 8'h04);
    rd(6'h0F, 1'b0, 8'h04);
    rd(6'h0F, 1'b1, 8'hFC);
    fl(4'h8, 8'h00, 10'h000);
    chk(irq_request, 1'b1);
    fl(4'h9, 8'h00, 10'h000);
    chk(irq_request, 1'b0);
    fl(4'h8, 8'h00, 10'h000);
    @(posedge clk) irq_entry <= 1'b1;
    @(posedge clk) irq_entry <= 1'b0;
    #1;
    chk(irq_request, 1'b0);
    wr(6'h0F, 1'b0, 8'h00);
    wr(6'h0F, 1'b0, 8'hFF);
    rd(6'h0F, 1'b0, 8'h00);
    // flow: jump, call, returns, program counter write
    fl(4'h1, 8'h00, 10'h3FF);
    chk(program_counter, 10'h3FF);
    fl(4'h2, 8'h00, 10'h123);
    saved = pc_at + 10'h001;
    chk(program_counter, 10'h123);
    fl(4'h3, 8'h00, 10'h000);
    chk(program_counter, saved);
    fl(4'h2, 8'h00, 10'h2C5);
    saved = pc_at + 10'h001;
    fl(4'h4, 8'h00, 10'h000);
    chk(program_counter, saved);
    fl(4'h1, 8'h00, 10'h3C0);
    wr(6'h02, 1'b0, 8'h77);
    chk(program_counter, 10'h077);
    fl(4'h2, 8'h00, 10'h200);
    saved = pc_at + 10'h001;
    fl(4'h5, 8'h00, 10'h000);
    chk(program_counter, saved);
    op_do(4'h7, 26'h0);
    chk(reg_rdata[6], 1'b1);
    wrap_up();
  end
endmodule
